// ==== rtl/membus_defs.vh ====
`ifndef MEMBUS_DEFS_VH
`define MEMBUS_DEFS_VH

// Bus cycle states
`define MB_ST_IDLE      3'h0
`define MB_ST_ROW       3'h1
`define MB_ST_COL       3'h2
`define MB_ST_ALE       3'h3
`define MB_ST_STRB      3'h4
`define MB_ST_TURN      3'h5

// Access targets
`define MB_TGT_DRAM0    4'h0
`define MB_TGT_DRAM1    4'h1
`define MB_TGT_SDRAM0   4'h2
`define MB_TGT_SDRAM1   4'h3
`define MB_TGT_CS0      4'h4
`define MB_TGT_CS3      4'h7
`define MB_TGT_EXT0     4'h8
`define MB_TGT_EXT1     4'h9
`define MB_TGT_CARD1    4'hA
`define MB_TGT_CARD2    4'hB
`define MB_TGT_INTERNAL 4'hC

// Address split
`define MB_ADDR_W       26
`define MB_PIN_ADDR_W   13
`define MB_UPPER_LSB    13

// Phase lengths in clock cycles
`define MB_ROW_CYCLES   2
`define MB_COL_CYCLES   2
`define MB_ALE_CYCLES   1
`define MB_STRB_CYCLES  3

// Logical lane 0 strobe
`define MB_LANE0_MASK   4'h1

`endif

// ==== rtl/lane_steer.v ====
`timescale 1ns/1ns
`default_nettype none

module lane_steer (
  // Steering controls
  input  wire        to_pins,
  input  wire        wide,
  input  wire        low_half,
  input  wire        little,
  // Data and lane mask
  input  wire [31:0] din,
  input  wire [3:0]  mask_in,
  output reg  [31:0] dout,
  output reg  [3:0]  mask_out
);

  reg [31:0] placed;
  reg [31:0] unswapped;
  reg [3:0]  mplaced;

  always @* begin
    placed    = 32'h0;
    unswapped = 32'h0;
    mplaced   = 4'h0;
    dout      = 32'h0;
    mask_out  = 4'h0;
    if (to_pins) begin
      if (wide) begin
        placed  = din;
        mplaced = mask_in;
      end else if (low_half) begin
        placed  = {16'h0, din[15:0]};
        mplaced = {2'h0, mask_in[1:0]};
      end else begin
        placed  = {din[15:0], 16'h0};
        mplaced = {mask_in[1:0], 2'h0};
      end
      // Little-endian pin order reverses byte lanes and strobe indices
      if (little) begin
        dout     = {placed[7:0], placed[15:8], placed[23:16], placed[31:24]};
        mask_out = {mplaced[0], mplaced[1], mplaced[2], mplaced[3]};
      end else begin
        dout     = placed;
        mask_out = mplaced;
      end
    end else begin
      if (little)
        unswapped = {din[7:0], din[15:8], din[23:16], din[31:24]};
      else
        unswapped = din;
      if (wide)
        dout = unswapped;
      else if (low_half)
        dout = {16'h0, unswapped[15:0]};
      else
        dout = {16'h0, unswapped[31:16]};
      mask_out = mask_in;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/membus_pins.v ====
`timescale 1ns/1ns
`default_nettype none
`include "membus_defs.vh"

module membus_pins #(
  parameter ROW_CYCLES  = `MB_ROW_CYCLES,
  parameter COL_CYCLES  = `MB_COL_CYCLES,
  parameter ALE_CYCLES  = `MB_ALE_CYCLES,
  parameter STRB_CYCLES = `MB_STRB_CYCLES
) (
  // Clock and reset
  input  wire        CLK,
  input  wire        RESET_N,
  // Access request
  input  wire        REQ_VALID,
  output wire        REQ_READY,
  input  wire        REQ_WRITE,
  input  wire [3:0]  REQ_TARGET,
  input  wire        REQ_WIDE,
  input  wire [25:0] REQ_ADDR,
  input  wire [31:0] REQ_WDATA,
  input  wire [3:0]  REQ_BYTE_EN,
  // Access completion
  output wire        RSP_VALID,
  output wire [31:0] RSP_RDATA,
  input  wire [31:0] INT_RDATA,
  // Mode inputs
  input  wire        ENDIAN_LITTLE,
  input  wire        INTERNAL_ACCESS_SHOW,
  // Data bus pins
  input  wire [31:0] D_IN,
  output wire [31:0] D_OUT,
  output wire        D_OE,
  // Address pins
  output wire [12:0] ADDR_OUT,
  output wire        ADDR_LATCH_EN,
  // Strobes
  output wire        READ_STROBE_N,
  output wire        WRITE_STROBE_N,
  output wire [3:0]  COLUMN_STROBE_LANE_N,
  output wire        ROW_STROBE_BANK0_N,
  output wire        ROW_STROBE_BANK1_N,
  // Selects
  output wire [3:0]  STATIC_CHIP_SELECT_N,
  output wire [1:0]  EXTERNAL_DEVICE_SELECT_N,
  output wire        CARD_SLOT1_SELECT_N,
  output wire        CARD_SLOT2_SELECT_N
);

  localparam [31:0] ROW_LAST = ROW_CYCLES - 1, COL_LAST = COL_CYCLES - 1;
  localparam [31:0] ALE_LAST = ALE_CYCLES - 1, STRB_LAST = STRB_CYCLES - 1;

  reg  [2:0]  state_reg, state_next;
  reg  [3:0]  cnt_reg, cnt_next;
  reg  [3:0]  tgt_reg;
  reg  [25:0] addr_reg;
  reg  [3:0]  mask_reg;
  reg         write_reg, wide_reg, little_reg, show_reg;

  reg  [31:0] dout_reg, dout_next;
  reg         doe_reg, doe_next;
  reg  [12:0] addr_out_reg, addr_out_next;
  reg         ale_reg, ale_next;
  reg         rd_n_reg, rd_n_next;
  reg         we_n_reg, we_n_next;
  reg  [3:0]  cas_n_reg, cas_n_next;
  reg         row_strobe_bank0_n_reg, row_strobe_bank0_n_next;
  reg         row_strobe_bank1_n_reg, row_strobe_bank1_n_next;
  reg  [3:0]  cs_n_reg, cs_n_next;
  reg  [1:0]  ext_n_reg, ext_n_next;
  reg         card1_n_reg, card1_n_next;
  reg         card2_n_reg, card2_n_next;
  reg         rsp_valid_reg;
  reg  [31:0] rdata_reg;

  wire        accept, in_idle, wr_cur, wide_cur, little_cur, show_cur;
  wire        is_dram, is_sdram, is_mem, is_int, is_static, phase_last;
  wire [3:0]  tgt_cur, mask_pins, lane0_pin;
  wire [25:0] addr_cur;
  wire [31:0] wdata_pins, rdata_user;

  assign in_idle    = (state_reg == `MB_ST_IDLE);
  assign accept     = in_idle & REQ_VALID;
  assign REQ_READY  = in_idle;
  assign wr_cur     = in_idle ? REQ_WRITE : write_reg;
  assign tgt_cur    = in_idle ? REQ_TARGET : tgt_reg;
  assign wide_cur   = in_idle ? REQ_WIDE : wide_reg;
  assign addr_cur   = in_idle ? REQ_ADDR : addr_reg;
  // Endian and show modes are sampled once per access
  assign little_cur = in_idle ? ENDIAN_LITTLE : little_reg;
  assign show_cur   = in_idle ? INTERNAL_ACCESS_SHOW : show_reg;

  assign is_dram    = (tgt_cur == `MB_TGT_DRAM0) | (tgt_cur == `MB_TGT_DRAM1);
  assign is_sdram   = (tgt_cur == `MB_TGT_SDRAM0) |
                      (tgt_cur == `MB_TGT_SDRAM1);
  assign is_mem     = is_dram | is_sdram;
  assign is_int     = (tgt_cur >= `MB_TGT_INTERNAL);
  assign is_static  = ~is_mem & ~is_int;
  assign phase_last = (cnt_reg == 4'h0);
  assign lane0_pin  = little_cur ? 4'h8 : `MB_LANE0_MASK;

  // Write data and lane mask placed onto pins at acceptance
  lane_steer u_wr_steer (
    .to_pins  (1'b1),
    .wide     (REQ_WIDE),
    .low_half (REQ_TARGET < `MB_TGT_CS0),
    .little   (ENDIAN_LITTLE),
    .din      (REQ_WDATA),
    .mask_in  (REQ_BYTE_EN),
    .dout     (wdata_pins),
    .mask_out (mask_pins)
  );

  // Read data gathered back from pins
  lane_steer u_rd_steer (
    .to_pins  (1'b0),
    .wide     (wide_reg),
    .low_half (tgt_reg < `MB_TGT_CS0),
    .little   (little_reg),
    .din      (D_IN),
    .mask_in  (4'h0),
    .dout     (rdata_user),
    .mask_out ()
  );

  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (cnt_reg != 4'h0)
      cnt_next = cnt_reg - 4'h1;
    case (state_reg)
      `MB_ST_IDLE: begin
        if (REQ_VALID) begin
          if (is_mem) begin
            state_next = `MB_ST_ROW;
            cnt_next   = ROW_LAST[3:0];
          end else if (is_static) begin
            state_next = `MB_ST_ALE;
            cnt_next   = ALE_LAST[3:0];
          end else begin
            state_next = `MB_ST_STRB;
            cnt_next   = STRB_LAST[3:0];
          end
        end
      end
      `MB_ST_ROW: begin
        if (phase_last) begin
          state_next = `MB_ST_COL;
          cnt_next   = COL_LAST[3:0];
        end
      end
      `MB_ST_COL: begin
        if (phase_last)
          state_next = `MB_ST_TURN;
      end
      `MB_ST_ALE: begin
        if (phase_last) begin
          state_next = `MB_ST_STRB;
          cnt_next   = STRB_LAST[3:0];
        end
      end
      `MB_ST_STRB: begin
        if (phase_last)
          state_next = `MB_ST_TURN;
      end
      `MB_ST_TURN: state_next = `MB_ST_IDLE;
      default: state_next = `MB_ST_IDLE;
    endcase
  end

  always @* begin
    dout_next     = accept ? wdata_pins : dout_reg;
    // Bus floats only from a read's start through its turn-around
    doe_next      = 1'b1;
    addr_out_next = addr_out_reg;
    ale_next      = 1'b0;
    rd_n_next     = 1'b1;
    we_n_next     = 1'b1;
    cas_n_next    = 4'hF;
    row_strobe_bank0_n_next   = 1'b1;
    row_strobe_bank1_n_next   = 1'b1;
    cs_n_next     = 4'hF;
    ext_n_next    = 2'h3;
    card1_n_next  = 1'b1;
    card2_n_next  = 1'b1;
    if (state_next != `MB_ST_IDLE) begin
      doe_next = wr_cur;
      if (state_next != `MB_ST_TURN) begin
        if (is_static) begin
          cs_n_next[tgt_cur[1:0]] = ~((tgt_cur >= `MB_TGT_CS0) &
                                      (tgt_cur <= `MB_TGT_CS3));
          ext_n_next[0] = (tgt_cur != `MB_TGT_EXT0);
          ext_n_next[1] = (tgt_cur != `MB_TGT_EXT1);
          card1_n_next  = (tgt_cur != `MB_TGT_CARD1);
          card2_n_next  = (tgt_cur != `MB_TGT_CARD2);
        end
        // SDRAM bank 1 select stays low for its whole access
        if (tgt_cur == `MB_TGT_SDRAM1)
          row_strobe_bank1_n_next = 1'b0;
        if (tgt_cur == `MB_TGT_DRAM0)
          row_strobe_bank0_n_next = 1'b0;
        if (tgt_cur == `MB_TGT_DRAM1)
          row_strobe_bank1_n_next = 1'b0;
      end
    end
    case (state_next)
      `MB_ST_ROW: begin
        addr_out_next = addr_cur[25:13];
        if (is_sdram)
          row_strobe_bank0_n_next = 1'b0;
      end
      `MB_ST_COL: begin
        addr_out_next = addr_cur[12:0];
        we_n_next     = ~wr_cur;
        if (is_sdram)
          cas_n_next = ~lane0_pin;
        else
          cas_n_next = ~(accept ? mask_pins : mask_reg);
      end
      `MB_ST_ALE: begin
        addr_out_next = addr_cur[25:13];
        ale_next      = 1'b1;
      end
      `MB_ST_STRB: begin
        if (is_static) begin
          addr_out_next = addr_cur[12:0];
          rd_n_next     = wr_cur;
          we_n_next     = ~wr_cur;
          if (wr_cur)
            cas_n_next = ~mask_reg;
        end else begin
          // Internal reads show on the bus strobe only for debug
          rd_n_next = ~(~wr_cur & show_cur & is_int);
        end
      end
      default: addr_out_next = addr_out_reg;
    endcase
  end

  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg     <= `MB_ST_IDLE;
      cnt_reg       <= 4'h0;
      write_reg     <= 1'b0;
      tgt_reg       <= `MB_TGT_DRAM0;
      wide_reg      <= 1'b0;
      addr_reg      <= 26'h0;
      mask_reg      <= 4'h0;
      little_reg    <= 1'b0;
      show_reg      <= 1'b0;
      dout_reg      <= 32'h0;
      doe_reg       <= 1'b1;
      addr_out_reg  <= 13'h0;
      ale_reg       <= 1'b0;
      rd_n_reg      <= 1'b1;
      we_n_reg      <= 1'b1;
      cas_n_reg     <= 4'hF;
      row_strobe_bank0_n_reg    <= 1'b1;
      row_strobe_bank1_n_reg    <= 1'b1;
      cs_n_reg      <= 4'hF;
      ext_n_reg     <= 2'h3;
      card1_n_reg   <= 1'b1;
      card2_n_reg   <= 1'b1;
      rsp_valid_reg <= 1'b0;
      rdata_reg     <= 32'h0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      if (accept) begin
        write_reg  <= REQ_WRITE;
        tgt_reg    <= REQ_TARGET;
        wide_reg   <= REQ_WIDE;
        addr_reg   <= REQ_ADDR;
        mask_reg   <= mask_pins;
        little_reg <= ENDIAN_LITTLE;
        show_reg   <= INTERNAL_ACCESS_SHOW;
      end
      dout_reg      <= dout_next;
      doe_reg       <= doe_next;
      addr_out_reg  <= addr_out_next;
      ale_reg       <= ale_next;
      rd_n_reg      <= rd_n_next;
      we_n_reg      <= we_n_next;
      cas_n_reg     <= cas_n_next;
      row_strobe_bank0_n_reg    <= row_strobe_bank0_n_next;
      row_strobe_bank1_n_reg    <= row_strobe_bank1_n_next;
      cs_n_reg      <= cs_n_next;
      ext_n_reg     <= ext_n_next;
      card1_n_reg   <= card1_n_next;
      card2_n_reg   <= card2_n_next;
      rsp_valid_reg <= (state_next == `MB_ST_TURN);
      // Read data sampled on the last strobe edge
      if (~write_reg & phase_last &
          ((state_reg == `MB_ST_COL) | (state_reg == `MB_ST_STRB)))
        rdata_reg <= (tgt_reg >= `MB_TGT_INTERNAL) ? INT_RDATA : rdata_user;
    end
  end

  assign RSP_VALID                = rsp_valid_reg;
  assign RSP_RDATA                = rdata_reg;
  assign D_OUT                    = dout_reg;
  assign D_OE                     = doe_reg;
  assign ADDR_OUT                 = addr_out_reg;
  assign ADDR_LATCH_EN            = ale_reg;
  assign READ_STROBE_N            = rd_n_reg;
  assign WRITE_STROBE_N           = we_n_reg;
  assign COLUMN_STROBE_LANE_N     = cas_n_reg;
  assign ROW_STROBE_BANK0_N       = row_strobe_bank0_n_reg;
  assign ROW_STROBE_BANK1_N       = row_strobe_bank1_n_reg;
  assign STATIC_CHIP_SELECT_N     = cs_n_reg;
  assign EXTERNAL_DEVICE_SELECT_N = ext_n_reg;
  assign CARD_SLOT1_SELECT_N      = card1_n_reg;
  assign CARD_SLOT2_SELECT_N      = card2_n_reg;

endmodule

`default_nettype wire

// ==== verif/membus_pins_checker.sv ====
`timescale 1ns/1ns
`default_nettype none
module membus_pins_checker #(
  parameter ROW_CYCLES  = 2,
  parameter COL_CYCLES  = 2,
  parameter ALE_CYCLES  = 1,
  parameter STRB_CYCLES = 3
) (
  // Clock, reset and request side
  input wire logic        CLK, RESET_N, REQ_VALID, REQ_READY, REQ_WRITE,
  input wire logic        REQ_WIDE, RSP_VALID, ENDIAN_LITTLE,
  input wire logic        INTERNAL_ACCESS_SHOW,
  input wire logic [3:0]  REQ_TARGET, REQ_BYTE_EN,
  input wire logic [25:0] REQ_ADDR,
  input wire logic [31:0] REQ_WDATA, INT_RDATA, RSP_RDATA, D_IN, D_OUT,
  // Pins
  input wire logic        D_OE, ADDR_LATCH_EN, READ_STROBE_N, WRITE_STROBE_N,
  input wire logic        ROW_STROBE_BANK0_N, ROW_STROBE_BANK1_N,
  input wire logic        CARD_SLOT1_SELECT_N, CARD_SLOT2_SELECT_N,
  input wire logic [12:0] ADDR_OUT,
  input wire logic [3:0]  COLUMN_STROBE_LANE_N, STATIC_CHIP_SELECT_N,
  input wire logic [1:0]  EXTERNAL_DEVICE_SELECT_N
);
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wire take = REQ_VALID && REQ_READY;
  wire stat = take && REQ_TARGET >= 4'h4 && REQ_TARGET <= 4'hB;
  wire dram = take && REQ_TARGET <= 4'h3;
  wire intr = take && REQ_TARGET >= 4'hC;
  wire idle = &{READ_STROBE_N, WRITE_STROBE_N, COLUMN_STROBE_LANE_N,
    ROW_STROBE_BANK0_N, ROW_STROBE_BANK1_N, STATIC_CHIP_SELECT_N,
    EXTERNAL_DEVICE_SELECT_N, CARD_SLOT1_SELECT_N, CARD_SLOT2_SELECT_N};

  AST_IDLE_HIGH: assert property (REQ_READY |-> idle && !ADDR_LATCH_EN)
    else $error("strobe active while idle");
  AST_WRITE_DRIVES: assert property (take && REQ_WRITE |=> D_OE [*4])
    else $error("data bus released during write");
  AST_TURN_BACK: assert property (RSP_VALID |=> D_OE)
    else $error("data bus not driven after access");
  AST_ROW_COL_MUX: assert property (dram |=>
    ADDR_OUT == $past(REQ_ADDR[25:13])
    ##2 ADDR_OUT == $past(REQ_ADDR[12:0], 3))
    else $error("row or column address wrong");
  AST_UPPER_LATCH: assert property (stat |=>
    ADDR_LATCH_EN && ADDR_OUT == $past(REQ_ADDR[25:13]) ##1 !ADDR_LATCH_EN)
    else $error("upper address latch phase wrong");
  AST_LOWER_HELD: assert property (stat |->
    ##2 ADDR_OUT == $past(REQ_ADDR[12:0], 2) ##1 $stable(ADDR_OUT) [*2])
    else $error("lower address not held");
  AST_STATIC_READ: assert property (stat && !REQ_WRITE |->
    ##2 !READ_STROBE_N [*3])
    else $error("read strobe missing on static read");
  AST_SHOW_READ: assert property (
    intr && !REQ_WRITE && INTERNAL_ACCESS_SHOW |=> !READ_STROBE_N [*3])
    else $error("read strobe missing on shown internal read");
  AST_WRITE_STROBE: assert property (
    (stat || dram) && REQ_WRITE |-> ##[2:3] !WRITE_STROBE_N)
    else $error("write strobe missing");
  AST_SDRAM_COLUMN: assert property (
    dram && REQ_TARGET[1] && !ENDIAN_LITTLE |-> ##3 COLUMN_STROBE_LANE_N == 4'hE)
    else $error("column strobe wrong for synchronous memory");
  AST_ROW_BANK0: assert property (dram && !REQ_TARGET[0] |=>
    !ROW_STROBE_BANK0_N && ROW_STROBE_BANK1_N)
    else $error("bank 0 row strobe wrong");
  AST_ROW_BANK1: assert property (dram && REQ_TARGET[0] |=>
    !ROW_STROBE_BANK1_N)
    else $error("bank 1 row strobe wrong");

  cover property (stat && !REQ_WRITE);
  cover property (dram && REQ_WRITE);
  cover property (intr && INTERNAL_ACCESS_SHOW);
endmodule
bind membus_pins membus_pins_checker #(.ROW_CYCLES(ROW_CYCLES),
  .COL_CYCLES(COL_CYCLES), .ALE_CYCLES(ALE_CYCLES),
  .STRB_CYCLES(STRB_CYCLES)) membus_pins_checker_i (.*);
`default_nettype wire

// ==== verif/mem_far_side.sv ====
`timescale 1ns/1ns
`default_nettype none
module mem_far_side #(
  parameter logic [31:0] RD_PATTERN = 32'h5A3C96E1
) (
  // Clock
  input wire logic        CLK,
  // Pins from the device
  input wire logic        D_OE, READ_STROBE_N, ADDR_LATCH_EN,
  input wire logic [3:0]  COLUMN_STROBE_LANE_N,
  input wire logic [12:0] ADDR_OUT,
  // Data back to the device
  output wire logic [31:0] D_IN
);
  logic [31:0] last_reg  = 32'h00000000;
  logic [12:0] upper_reg = 13'h0000;
  wire reading = !D_OE && (!READ_STROBE_N || !(&COLUMN_STROBE_LANE_N));
  // Undriven bus flips every cycle so a stale sample cannot pass
  assign D_IN = reading ? RD_PATTERN : ~last_reg;
  always @(posedge CLK) begin
    last_reg <= D_IN;
    if (ADDR_LATCH_EN) begin
      upper_reg <= ADDR_OUT;
    end
  end
endmodule
`default_nettype wire

// ==== verif/external_memory_bus_pins_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "membus_defs.vh"
module external_memory_bus_pins_tb;
  localparam logic [31:0] PAT = 32'h5A3C96E1;
  localparam logic [31:0] WD  = 32'hA1B2C3D4;
  localparam logic [25:0] AD  = 26'h2B4C1A5;
  localparam logic [31:0] ID  = 32'h0F1E2D3C;
  typedef struct packed {
    logic wr; logic [3:0] tgt; logic wide, lit, shw; logic [3:0] be;
    logic rd_x, wr_x; logic [3:0] col_x; logic [1:0] row_x; logic [7:0] sel_x;
  } row_t;
  logic        CLK = 0, RESET_N = 0, REQ_VALID = 0, REQ_WRITE = 0;
  logic        REQ_WIDE = 0, ENDIAN_LITTLE = 0, INTERNAL_ACCESS_SHOW = 0;
  logic [3:0]  REQ_TARGET = 4'h0, REQ_BYTE_EN = 4'h0;
  logic [25:0] REQ_ADDR = AD;
  logic [31:0] REQ_WDATA = WD, INT_RDATA = ID;
  wire logic [31:0] D_IN, D_OUT, RSP_RDATA;
  wire logic REQ_READY, RSP_VALID, D_OE, ADDR_LATCH_EN;
  wire logic READ_STROBE_N, WRITE_STROBE_N, ROW_STROBE_BANK0_N;
  wire logic ROW_STROBE_BANK1_N, CARD_SLOT1_SELECT_N, CARD_SLOT2_SELECT_N;
  wire logic [12:0] ADDR_OUT;
  wire logic [3:0]  COLUMN_STROBE_LANE_N, STATIC_CHIP_SELECT_N;
  wire logic [1:0]  EXTERNAL_DEVICE_SELECT_N;
  wire logic [7:0]  sel = ~{CARD_SLOT2_SELECT_N, CARD_SLOT1_SELECT_N,
    EXTERNAL_DEVICE_SELECT_N, STATIC_CHIP_SELECT_N};
  wire logic idle = &{READ_STROBE_N, WRITE_STROBE_N, COLUMN_STROBE_LANE_N,
    ROW_STROBE_BANK0_N, ROW_STROBE_BANK1_N, ~sel};
  int errors = 0, compares = 0, cyc = 0;
  // wr tgt wide lit shw be | rd wr col row sel
  row_t rows [14] = '{
    '{1,4'h0,0,0,0,4'h3, 0,1,4'h3,2'h1,8'h00},
    '{0,4'h1,0,0,0,4'hF, 0,0,4'h0,2'h2,8'h00},
    '{1,4'h2,1,0,0,4'hF, 0,1,4'h1,2'h1,8'h00},
    '{0,4'h3,1,0,0,4'hF, 0,0,4'h0,2'h3,8'h00},
    '{1,4'h4,1,0,0,4'hA, 0,1,4'hA,2'h0,8'h01},
    '{0,4'h7,0,0,0,4'hF, 1,0,4'h0,2'h0,8'h08},
    '{1,4'h8,0,0,0,4'h1, 0,1,4'h4,2'h0,8'h10},
    '{0,4'h9,1,0,0,4'hF, 1,0,4'h0,2'h0,8'h20},
    '{0,4'hA,0,0,0,4'hF, 1,0,4'h0,2'h0,8'h40},
    '{1,4'hB,0,0,0,4'h2, 0,1,4'h8,2'h0,8'h80},
    '{0,4'hC,1,0,1,4'hF, 1,0,4'h0,2'h0,8'h00},
    '{0,4'hC,1,0,0,4'hF, 0,0,4'h0,2'h0,8'h00},
    '{1,4'h5,1,1,0,4'h1, 0,1,4'h8,2'h0,8'h02},
    '{0,4'h6,1,1,0,4'hF, 1,0,4'h0,2'h0,8'h04}};

  always #10 CLK = ~CLK;
  membus_pins membus_pins_i (.*);
  mem_far_side #(.RD_PATTERN(PAT)) mem_far_side_i (.*);

  task automatic check_val(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic run(input row_t r);
    logic [31:0] xd, xm, xr, dq, pv;
    logic [12:0] a_first, a_last, up;
    logic [7:0]  sl;
    logic [3:0]  col;
    logic [1:0]  rw;
    logic        rd, we, oe_lo, rdy;
    int          n, nx;
    // Read data is gathered from the pins after the lane swap
    pv = r.lit ? {<<8{PAT}} : PAT;
    xd = r.wide ? WD : (r.tgt < 4 ? {16'h0, WD[15:0]} : {WD[15:0], 16'h0});
    xm = r.wide ? 32'hFFFFFFFF : (r.tgt < 4 ? 32'h0000FFFF : 32'hFFFF0000);
    xr = r.wide ? pv : (r.tgt < 4 ? {16'h0, pv[15:0]} : {16'h0, pv[31:16]});
    if (r.lit) begin
      xd = {<<8{xd}};
      xm = {<<8{xm}};
    end
    nx = r.tgt < 4'h4 ? `MB_ROW_CYCLES + `MB_COL_CYCLES :
         r.tgt < 4'hC ? `MB_ALE_CYCLES + `MB_STRB_CYCLES : `MB_STRB_CYCLES;
    if (r.tgt >= 4'hC) begin
      xr = ID;
    end
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ_WRITE <= r.wr;
    REQ_TARGET <= r.tgt;
    REQ_WIDE <= r.wide;
    ENDIAN_LITTLE <= r.lit;
    INTERNAL_ACCESS_SHOW <= r.shw;
    REQ_BYTE_EN <= r.be;
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    {sl, col, rw, rd, we, oe_lo, rdy, n, dq} = '0;
    @(negedge CLK);
    a_first = ADDR_OUT;
    while (RSP_VALID !== 1'b1 && n < 12) begin
      a_last = ADDR_OUT;
      sl |= sel;
      col |= ~COLUMN_STROBE_LANE_N;
      rw |= ~{ROW_STROBE_BANK1_N, ROW_STROBE_BANK0_N};
      rd |= !READ_STROBE_N;
      we |= !WRITE_STROBE_N;
      oe_lo |= !D_OE;
      rdy |= REQ_READY;
      if (!WRITE_STROBE_N) begin
        dq = D_OUT;
      end
      @(negedge CLK);
      n++;
    end
    up = mem_far_side_i.upper_reg;
    check_val("access cycles", nx, n);
    check_flag("ready in access", 1'b0, rdy);
    check_flag("read strobe", r.rd_x, rd);
    check_flag("write strobe", r.wr_x, we);
    check_val("selects", {24'h0, r.sel_x}, {24'h0, sl});
    check_val("row strobes", {30'h0, r.row_x}, {30'h0, rw});
    if (r.tgt < 4'hC) begin
      check_flag("bus released", !r.wr, oe_lo);
      check_val("first addr", {19'h0, AD[25:13]}, {19'h0, a_first});
      check_val("held addr", {19'h0, AD[12:0]}, {19'h0, a_last});
      if (r.tgt >= 4'h4) begin
        check_val("upper", {19'h0, AD[25:13]}, {19'h0, up});
      end
    end
    if (r.wr) begin
      check_val("col strobes", {28'h0, r.col_x}, {28'h0, col});
      check_val("write data", xd & xm, dq & xm);
    end else begin
      check_val("read data", xr, RSP_RDATA);
    end
  endtask

  // Ceiling is several times the expected run, so only a hang reaches it
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 1000) begin
      errors++;
      $display("ERROR timeout expected done seen hang");
      test_done();
    end
  end

  initial begin
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    @(negedge CLK);
    check_flag("idle after reset", 1'b1, idle);
    for (int i = 0; i < 14; i++) begin
      run(rows[i]);
      $display("Test row %0d done", i);
    end
    // Reset in mid-read must restore idle strobes and a driven bus
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    @(posedge CLK);
    RESET_N <= 1'b0;
    @(negedge CLK);
    check_flag("idle in reset", 1'b1, idle);
    check_flag("bus driven in reset", 1'b1, D_OE);
    @(posedge CLK);
    RESET_N <= 1'b1;
    run(rows[3]);
    $display("Test reset in mid-access done");
    test_done();
  end
endmodule
`default_nettype wire
